// ---- inc/scc_regs.svh ----
// Register map, field positions, reset values and timing counts of the
// clock compensation combiner. Included by the package and by the testbench.
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// Register indices; byte address on APB is four times the index
`define SCC_IDX_ROUTE_AUX 14'h0280
`define SCC_IDX_ROUTE_OSC 14'h0281
`define SCC_IDX_ROUTE_MAIN 14'h0282
`define SCC_IDX_SLEW 14'h0283
`define SCC_IDX_BW_LO 14'h0285
`define SCC_IDX_BW_HI 14'h0286
`define SCC_IDX_ERR_SRC 14'h0287
`define SCC_IDX_NOM0 14'h0290
`define SCC_IDX_NOM1 14'h0291
`define SCC_IDX_NOM2 14'h0292
`define SCC_IDX_LIVE 14'h3002
`define SCC_IDX_EVENT 14'h300C

// Field positions inside the 8-bit registers
`define SCC_SEL_LO 2:0
`define SCC_SEL_HI 6:4
`define SCC_SLEW_FIELD 2:0
`define SCC_ERR_SRC_BIT 0
`define SCC_LIVE_LOCK_BIT 1
`define SCC_LIVE_FAULT_BIT 2
`define SCC_EVT_LOCKED 0
`define SCC_EVT_UNLOCKED 1
`define SCC_EVT_FAULTED 2
`define SCC_EVT_UNFAULTED 3

// Reset values
`define SCC_RST_BYTE 8'h00
`define SCC_UNITY 32'h40000000

// Factor format: unsigned Q2.30, unity is 2^30
`define SCC_FRAC_BITS 30

// Reference monitor window, percent of nominal period
`define SCC_PCT_FULL 32'h00000064
`define SCC_PCT_HIGH 32'h00000065
`define SCC_PCT_LOW 32'h00000063

// Fixed lock detector thresholds: period error in clock cycles, lock count in reference edges
`define SCC_LOCK_ERR 25'sh0000002
`define SCC_UNLOCK_ERR 25'sh0000008
`define SCC_LOCK_EDGES 4'h8

// Slew: 0.715 ppm/s base rate, 25 MHz clock; cycles per unity-LSB step
`define SCC_CLK_HZ 64'h00000000017D7840
`define SCC_SLEW_BASE_PPB 64'h00000000000002CB
`define SCC_PPB_PER_UNIT 64'h000000003B9ACA00
`define SCC_SLEW_TICK_CYCLES ((`SCC_CLK_HZ * `SCC_PPB_PER_UNIT) / (`SCC_SLEW_BASE_PPB << 30))

`endif

// ---- inc/scc_pkg.sv ----
// Shared types of the clock compensation combiner.
// Assumes scc_regs.svh is on the include path.
`default_nettype none
`include "scc_regs.svh"

package scc_pkg;
	// Correction factor, unsigned Q2.30
	typedef logic [31:0] scc_factor_t;
	// Auxiliary loop operating mode
	typedef enum logic {SCC_AUX_HOLD, SCC_AUX_CLOSED} scc_auxmode_t;
	// Slew limit code
	typedef logic [2:0] scc_slew_t;
endpackage

`default_nettype wire

// ---- rtl/scc_slew_lim.sv ----
// Slew limiter for one composite correction factor.
// Assumes a one-cycle tick from the parent at the base step rate.
`default_nettype none

module scc_slew_lim
	import scc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Control
	input wire scc_slew_t code,
	input wire logic tick,
	// Data
	input wire scc_factor_t target,
	output scc_factor_t valueQ
);
	scc_factor_t valueD;
	scc_factor_t step;

	// Step doubles with each code; code 0 passes the target straight on
	always_comb begin
		step = 32'h00000001 << (code - 3'h1);
		valueD = valueQ;
		if (code == 3'h0) begin
			valueD = target;
		end else if (tick) begin
			if (target > valueQ) begin
				valueD = ((target - valueQ) > step) ? valueQ + step : target;
			end else begin
				valueD = ((valueQ - target) > step) ? valueQ - step : target;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			valueQ <= `SCC_UNITY;
		end else begin
			valueQ <= valueD;
		end
	end

	a_slew_bypass: assert property (@(posedge clock) disable iff (!reset_n)
		code == 3'h0 |=> valueQ == $past(target))
		else $error("slew bypass did not follow target");
	a_slew_still: assert property (@(posedge clock) disable iff (!reset_n)
		(code != 3'h0 && !tick) |=> $stable(valueQ))
		else $error("limited value moved without a tick");
	a_slew_bound: assert property (@(posedge clock) disable iff (!reset_n)
		(code != 3'h0 && tick) |=> ((valueQ >= $past(valueQ)) ?
		(valueQ - $past(valueQ)) <= $past(step) : ($past(valueQ) - valueQ) <= $past(step)))
		else $error("slew step exceeds limit");
endmodule

`default_nettype wire

// ---- rtl/scc_combiner.sv ----
// Clock compensation combiner, distributor and auxiliary loop with APB registers.
// Assumes factor inputs and the reference edge pulse come from logic on clock.
//
// Chosen here: register access over APB.
`default_nettype none

module scc_combiner
	import scc_pkg::*;
#(
	parameter int unsigned SLEW_TICK_CYCLES = 32'(`SCC_SLEW_TICK_CYCLES)
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Correction sources
	input wire scc_factor_t filteredCorrectionFactor,
	input wire scc_factor_t mainLoopZeroFactor,
	input wire scc_factor_t mainLoopOneFactor,
	input wire logic referenceEdge,
	// Destinations
	output scc_factor_t auxLoopComp,
	output scc_factor_t phaseTimeDetectorComp,
	output scc_factor_t auxOsc0Comp,
	output scc_factor_t auxOsc1Comp,
	output scc_factor_t mainLoopZeroComp,
	output scc_factor_t mainLoopOneComp,
	// Auxiliary loop state
	output scc_factor_t auxLoopCorrectionFactor,
	output logic auxHoldover
);
	// Register file
	logic [7:0] routeAuxQ, routeAuxD, routeOscQ, routeOscD, routeMainQ, routeMainD;
	logic [7:0] slewQ, slewD, bwLoQ, bwLoD, bwHiQ, bwHiD, errSrcQ, errSrcD;
	logic [7:0] nom0Q, nom0D, nom1Q, nom1D, nom2Q, nom2D;
	logic [3:0] eventQ, eventD;
	logic [31:0] prdataQ, prdataD;
	logic [13:0] regIdx;
	logic mapped, accessDone;
	// Auxiliary loop
	scc_auxmode_t modeQ, modeD;
	logic [23:0] periodCntQ, periodCntD, measured, nominal;
	logic faultQ, faultD, lockQ, lockD;
	logic [3:0] lockCntQ, lockCntD;
	logic signed [24:0] periodErr, absErr;
	logic signed [41:0] loopProd;
	logic [15:0] bandwidth;
	logic [31:0] measPct, cntPct, nomHigh, nomLow;
	scc_factor_t cf3Q, cf3D;
	// Combiner and distributor
	scc_factor_t channelLoopFactor;
	logic [63:0] prod12, prod13, prod23, prod123;
	scc_factor_t compRaw [8];
	scc_factor_t compOut [8];
	scc_factor_t destQ [6];
	scc_factor_t destD [6];
	logic [2:0] destSel [6];
	logic [15:0] tickCntQ, tickCntD;
	logic slewTick;

	assign regIdx = paddr[15:2];
	assign accessDone = psel && penable;
	assign pready = accessDone;
	assign prdata = prdataQ;
	assign bandwidth = {bwHiQ, bwLoQ};
	assign nominal = {nom2Q, nom1Q, nom0Q};

	// Address decode for both directions
	always_comb begin
		case (regIdx)
			`SCC_IDX_ROUTE_AUX, `SCC_IDX_ROUTE_OSC, `SCC_IDX_ROUTE_MAIN, `SCC_IDX_SLEW,
			`SCC_IDX_BW_LO, `SCC_IDX_BW_HI, `SCC_IDX_ERR_SRC, `SCC_IDX_NOM0,
			`SCC_IDX_NOM1, `SCC_IDX_NOM2, `SCC_IDX_LIVE, `SCC_IDX_EVENT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	// Unmapped or misaligned words answer with an error
	assign pslverr = accessDone && (!mapped || paddr[1:0] != 2'h0);

	// Register writes, read capture in the setup cycle, event flags
	always_comb begin
		routeAuxD = routeAuxQ;
		routeOscD = routeOscQ;
		routeMainD = routeMainQ;
		slewD = slewQ;
		bwLoD = bwLoQ;
		bwHiD = bwHiQ;
		errSrcD = errSrcQ;
		nom0D = nom0Q;
		nom1D = nom1Q;
		nom2D = nom2Q;
		prdataD = prdataQ;
		eventD = eventQ;
		if (accessDone && pwrite && !pslverr) begin
			case (regIdx)
				`SCC_IDX_ROUTE_AUX: routeAuxD = pwdata[7:0];
				`SCC_IDX_ROUTE_OSC: routeOscD = pwdata[7:0];
				`SCC_IDX_ROUTE_MAIN: routeMainD = pwdata[7:0];
				`SCC_IDX_SLEW: slewD = pwdata[7:0];
				`SCC_IDX_BW_LO: bwLoD = pwdata[7:0];
				`SCC_IDX_BW_HI: bwHiD = pwdata[7:0];
				`SCC_IDX_ERR_SRC: errSrcD = pwdata[7:0];
				`SCC_IDX_NOM0: nom0D = pwdata[7:0];
				`SCC_IDX_NOM1: nom1D = pwdata[7:0];
				`SCC_IDX_NOM2: nom2D = pwdata[7:0];
				default: errSrcD = errSrcQ;
			endcase
		end
		if (psel && !penable) begin
			case (regIdx)
				`SCC_IDX_ROUTE_AUX: prdataD = {24'h000000, routeAuxQ};
				`SCC_IDX_ROUTE_OSC: prdataD = {24'h000000, routeOscQ};
				`SCC_IDX_ROUTE_MAIN: prdataD = {24'h000000, routeMainQ};
				`SCC_IDX_SLEW: prdataD = {24'h000000, slewQ};
				`SCC_IDX_BW_LO: prdataD = {24'h000000, bwLoQ};
				`SCC_IDX_BW_HI: prdataD = {24'h000000, bwHiQ};
				`SCC_IDX_ERR_SRC: prdataD = {24'h000000, errSrcQ};
				`SCC_IDX_NOM0: prdataD = {24'h000000, nom0Q};
				`SCC_IDX_NOM1: prdataD = {24'h000000, nom1Q};
				`SCC_IDX_NOM2: prdataD = {24'h000000, nom2Q};
				`SCC_IDX_LIVE: prdataD = {29'h00000000, faultQ, lockQ, modeQ == SCC_AUX_HOLD};
				`SCC_IDX_EVENT: prdataD = {28'h0000000, eventQ};
				default: prdataD = 32'h00000000;
			endcase
		end
		// Reading the event register clears it; a new event in that cycle survives
		if (accessDone && !pwrite && !pslverr && regIdx == `SCC_IDX_EVENT) begin
			eventD = 4'h0;
		end
		if (lockD && !lockQ) eventD[`SCC_EVT_LOCKED] = 1'b1;
		if (!lockD && lockQ) eventD[`SCC_EVT_UNLOCKED] = 1'b1;
		if (faultD && !faultQ) eventD[`SCC_EVT_FAULTED] = 1'b1;
		if (!faultD && faultQ) eventD[`SCC_EVT_UNFAULTED] = 1'b1;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			routeAuxQ <= `SCC_RST_BYTE;
			routeOscQ <= `SCC_RST_BYTE;
			routeMainQ <= `SCC_RST_BYTE;
			slewQ <= `SCC_RST_BYTE;
			bwLoQ <= `SCC_RST_BYTE;
			bwHiQ <= `SCC_RST_BYTE;
			errSrcQ <= `SCC_RST_BYTE;
			nom0Q <= `SCC_RST_BYTE;
			nom1Q <= `SCC_RST_BYTE;
			nom2Q <= `SCC_RST_BYTE;
			prdataQ <= 32'h00000000;
			eventQ <= 4'h0;
		end else begin
			routeAuxQ <= routeAuxD;
			routeOscQ <= routeOscD;
			routeMainQ <= routeMainD;
			slewQ <= slewD;
			bwLoQ <= bwLoD;
			bwHiQ <= bwHiD;
			errSrcQ <= errSrcD;
			nom0Q <= nom0D;
			nom1Q <= nom1D;
			nom2Q <= nom2D;
			prdataQ <= prdataD;
			eventQ <= eventD;
		end
	end

	// Period measurement, monitor window, lock detector and holdover control
	always_comb begin
		measured = periodCntQ + 24'h000001;
		periodErr = $signed({1'b0, nominal}) - $signed({1'b0, measured});
		absErr = periodErr[24] ? -periodErr : periodErr;
		measPct = 32'({8'h00, measured} * `SCC_PCT_FULL);
		cntPct = 32'({8'h00, periodCntQ} * `SCC_PCT_FULL);
		nomHigh = 32'({8'h00, nominal} * `SCC_PCT_HIGH);
		nomLow = 32'({8'h00, nominal} * `SCC_PCT_LOW);
		// Both operands widened first so the product keeps every bit
		loopProd = 42'(periodErr) * 42'($signed({1'b0, bandwidth}));
		periodCntD = (periodCntQ == 24'hFFFFFF) ? periodCntQ : measured;
		faultD = faultQ;
		lockD = lockQ;
		lockCntD = lockCntQ;
		cf3D = cf3Q;
		modeD = modeQ;
		if (referenceEdge) begin
			periodCntD = 24'h000000;
			faultD = (measPct > nomHigh) || (measPct < nomLow);
			if (absErr > `SCC_UNLOCK_ERR) begin
				lockCntD = 4'h0;
				lockD = 1'b0;
			end else if (absErr <= `SCC_LOCK_ERR) begin
				lockCntD = (lockCntQ == `SCC_LOCK_EDGES) ? lockCntQ : lockCntQ + 4'h1;
				lockD = lockQ || (lockCntD == `SCC_LOCK_EDGES);
			end
			// Open loop in holdover: the factor is left as it was
			if (modeQ == SCC_AUX_CLOSED) begin
				cf3D = cf3Q + 32'(loopProd[41:8]);
			end
		end else if (cntPct > nomHigh) begin
			faultD = 1'b1;
		end
		case (modeQ)
			SCC_AUX_CLOSED: begin
				if (bandwidth == 16'h0000 || faultQ) begin
					modeD = SCC_AUX_HOLD;
				end
			end
			SCC_AUX_HOLD: begin
				if (bandwidth != 16'h0000 && !faultQ && lockQ) begin
					modeD = SCC_AUX_CLOSED;
				end
			end
			default: modeD = SCC_AUX_HOLD;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			periodCntQ <= 24'h000000;
			faultQ <= 1'b0;
			lockQ <= 1'b0;
			lockCntQ <= 4'h0;
			cf3Q <= `SCC_UNITY;
			modeQ <= SCC_AUX_HOLD;
		end else begin
			periodCntQ <= periodCntD;
			faultQ <= faultD;
			lockQ <= lockD;
			lockCntQ <= lockCntD;
			cf3Q <= cf3D;
			modeQ <= modeD;
		end
	end
	assign auxLoopCorrectionFactor = cf3Q;
	assign auxHoldover = (modeQ == SCC_AUX_HOLD);

	// Error source and the eight composites; products rescaled back to Q2.30
	assign channelLoopFactor = errSrcQ[`SCC_ERR_SRC_BIT] ? mainLoopOneFactor :
		mainLoopZeroFactor;
	always_comb begin
		prod12 = filteredCorrectionFactor * channelLoopFactor;
		prod13 = filteredCorrectionFactor * cf3Q;
		prod23 = channelLoopFactor * cf3Q;
		prod123 = prod12[61:30] * cf3Q;
		compRaw[0] = 32'h00000000;
		compRaw[1] = filteredCorrectionFactor;
		compRaw[2] = channelLoopFactor;
		compRaw[3] = prod12[61:30];
		compRaw[4] = cf3Q;
		compRaw[5] = prod13[61:30];
		compRaw[6] = prod23[61:30];
		compRaw[7] = prod123[61:30];
	end

	// Shared step timer; one tick per base-rate unity LSB
	always_comb begin
		slewTick = (tickCntQ == 16'(SLEW_TICK_CYCLES - 1));
		tickCntD = slewTick ? 16'h0000 : tickCntQ + 16'h0001;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tickCntQ <= 16'h0000;
		end else begin
			tickCntQ <= tickCntD;
		end
	end

	// Composite zero is never slewed, so an idle destination sees exactly zero
	assign compOut[0] = compRaw[0];
	for (genvar c = 1; c < 8; c++) begin : g_slew
		scc_slew_lim u_slew (
			.clock(clock),
			.reset_n(reset_n),
			.code(slewQ[`SCC_SLEW_FIELD]),
			.tick(slewTick),
			.target(compRaw[c]),
			.valueQ(compOut[c])
		);
	end

	// Distributor: each destination looks only at its own selector
	assign destSel[0] = routeAuxQ[`SCC_SEL_LO];
	assign destSel[1] = routeAuxQ[`SCC_SEL_HI];
	assign destSel[2] = routeOscQ[`SCC_SEL_LO];
	assign destSel[3] = routeOscQ[`SCC_SEL_HI];
	assign destSel[4] = routeMainQ[`SCC_SEL_LO];
	assign destSel[5] = routeMainQ[`SCC_SEL_HI];
	always_comb begin
		for (int d = 0; d < 6; d++) begin
			destD[d] = compOut[destSel[d]];
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int d = 0; d < 6; d++) begin
				destQ[d] <= 32'h00000000;
			end
		end else begin
			destQ <= destD;
		end
	end
	assign auxLoopComp = destQ[0];
	assign phaseTimeDetectorComp = destQ[1];
	assign auxOsc0Comp = destQ[2];
	assign auxOsc1Comp = destQ[3];
	assign mainLoopZeroComp = destQ[4];
	assign mainLoopOneComp = destQ[5];

	// Checks
	sequence s_bad_edge;
		referenceEdge && ((measPct > nomHigh) || (measPct < nomLow));
	endsequence
	sequence s_clear_cause;
		modeQ == SCC_AUX_HOLD && bandwidth != 16'h0000 && !faultQ && lockQ;
	endsequence
	a_fault_flag: assert property (@(posedge clock) disable iff (!reset_n)
		s_bad_edge |=> faultQ ##1 modeQ == SCC_AUX_HOLD)
		else $error("out-of-window period did not fault and hold");
	a_fault_event: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(faultQ) |-> eventQ[`SCC_EVT_FAULTED])
		else $error("fault rise not logged");
	a_lock_event: assert property (@(posedge clock) disable iff (!reset_n)
		$fell(lockQ) |-> eventQ[`SCC_EVT_UNLOCKED])
		else $error("unlock not logged");
	a_edge_only: assert property (@(posedge clock) disable iff (!reset_n)
		!referenceEdge |=> $stable(cf3Q))
		else $error("aux factor changed without an edge");
	a_bw_zero: assert property (@(posedge clock) disable iff (!reset_n)
		bandwidth == 16'h0000 [*2] |-> modeQ == SCC_AUX_HOLD)
		else $error("zero bandwidth not in holdover");
	a_hold_frozen: assert property (@(posedge clock) disable iff (!reset_n)
		modeQ == SCC_AUX_HOLD |=> $stable(cf3Q))
		else $error("aux factor moved in holdover");
	a_resume_loop: assert property (@(posedge clock) disable iff (!reset_n)
		s_clear_cause |=> modeQ == SCC_AUX_CLOSED)
		else $error("loop did not resume");
	a_comb_table: assert property (@(posedge clock) disable iff (!reset_n)
		compRaw[0] == 32'h00000000 && compRaw[4] == cf3Q && compRaw[2] == channelLoopFactor)
		else $error("composite table wrong");
	a_route_osc0: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1 |=> auxOsc0Comp == $past(compOut[routeOscQ[2:0]]))
		else $error("osc0 routing wrong");
	a_route_main1: assert property (@(posedge clock) disable iff (!reset_n)
		routeMainQ[6:4] == 3'h0 |=> mainLoopOneComp == 32'h00000000)
		else $error("idle destination not zero");
	a_err_source: assert property (@(posedge clock) disable iff (!reset_n)
		errSrcQ[0] |-> channelLoopFactor == mainLoopOneFactor)
		else $error("error source select wrong");
endmodule

`default_nettype wire

// ---- testbench/scc_combiner_tb.sv ----
// Self-checking bench for the compensation combiner: APB registers, composites, slew, aux loop.
// Assumes scc_regs.svh on the include path and the package compiled first.
`default_nettype none
`include "scc_regs.svh"

module scc_combiner_tb
	import scc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock, reset_n, psel, penable, pwrite, pready, pslverr, referenceEdge, auxHoldover;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd, c0, d0, cfLast;
	scc_factor_t fcf, m0, m1, auxLoopComp, ptdComp, osc0, osc1, mz, mo, cf3;
	logic err;
	int error_cnt, check_count, seed, cycles;
	logic [2:0] sel [6];
	logic es;

	// Short slew tick keeps the ramp tests brief
	scc_combiner #(.SLEW_TICK_CYCLES(4)) uut (.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .filteredCorrectionFactor(fcf),
		.mainLoopZeroFactor(m0), .mainLoopOneFactor(m1), .referenceEdge(referenceEdge),
		.auxLoopComp(auxLoopComp), .phaseTimeDetectorComp(ptdComp), .auxOsc0Comp(osc0),
		.auxOsc1Comp(osc1), .mainLoopZeroComp(mz), .mainLoopOneComp(mo),
		.auxLoopCorrectionFactor(cf3), .auxHoldover(auxHoldover));

	// Clock, 40 ns period
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Hang guard, well above the expected run length
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// One APB transfer; waits for pready, the hang guard bounds the wait
	task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so a following call never reassigns psel in this step
		@(posedge clock);
	endtask

	task automatic wreg(input logic [13:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd);
	endtask

	// Reference edge pulses at a fixed spacing; cfLast taken before the next pulse
	task automatic edges(input int n, input int sp);
		for (int i = 0; i < n; i++) begin
			referenceEdge <= 1'b1;
			@(posedge clock);
			referenceEdge <= 1'b0;
			repeat (sp - 1) @(posedge clock);
		end
		cfLast = cf3;
	endtask

	function automatic logic [31:0] mul(input logic [31:0] a, input logic [31:0] b);
		logic [63:0] p;
		p = a * b;
		return p[61:30];
	endfunction

	// Expected composite; aux factor is still its unity reset value here
	function automatic logic [31:0] compExp(input logic [2:0] k);
		logic [31:0] a, b, c;
		a = fcf;
		b = es ? m1 : m0;
		c = 32'h40000000;
		case (k)
			3'h0: return 32'h00000000;
			3'h1: return a;
			3'h2: return b;
			3'h3: return mul(a, b);
			3'h4: return c;
			3'h5: return mul(a, c);
			3'h6: return mul(b, c);
			default: return mul(mul(a, b), c);
		endcase
	endfunction

	initial begin
		seed = 39;
		error_cnt = 0;
		check_count = 0;
		cycles = 0;
		reset_n = 1'b0;
		{psel, penable, pwrite, referenceEdge} = 4'h0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		fcf = 32'h40000000;
		m0 = 32'h40000000;
		m1 = 32'h40000000;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		// Reset state and register access
		chk(cf3, 32'h40000000, "aux factor reset");
		chk(auxHoldover, 1'b1, "holdover after reset");
		apb(1'b0, `SCC_IDX_ROUTE_OSC, 8'h00);
		chk(rd, 32'h00000000, "route reset");
		// Nominal period is still zero, so any counted period is out of window
		apb(1'b0, `SCC_IDX_LIVE, 8'h00);
		chk(rd, 32'h00000005, "live reset");
		wreg(`SCC_IDX_LIVE, 8'hFF);
		chk(err, 1'b0, "ro write error");
		apb(1'b0, `SCC_IDX_LIVE, 8'h00);
		chk(rd, 32'h00000005, "live after write");
		apb(1'b0, 14'h0284, 8'h00);
		chk(err, 1'b1, "unmapped read error");
		chk(rd, 32'h00000000, "unmapped read data");
		wreg(`SCC_IDX_SLEW, 8'h00);
		// Every composite index on aux osc 0, random picks elsewhere
		for (int i = 0; i < 8; i++) begin
			es = i[0];
			fcf <= 32'h40000000 + ($random(seed) & 32'h00FFFFFF);
			m0 <= 32'h40000000 + ($random(seed) & 32'h00FFFFFF);
			m1 <= 32'h3F000000 + ($random(seed) & 32'h00FFFFFF);
			foreach (sel[j]) sel[j] = 3'($random(seed));
			sel[2] = i[2:0];
			// Software duties: no self feedback, matched timestamp pair
			sel[0][2] = 1'b0;
			sel[es ? 5 : 4][1] = 1'b0;
			sel[3] = sel[1];
			wreg(`SCC_IDX_ERR_SRC, {7'h00, es});
			wreg(`SCC_IDX_ROUTE_AUX, {1'b0, sel[1], 1'b0, sel[0]});
			wreg(`SCC_IDX_ROUTE_OSC, {1'b0, sel[3], 1'b0, sel[2]});
			wreg(`SCC_IDX_ROUTE_MAIN, {1'b0, sel[5], 1'b0, sel[4]});
			repeat (4) @(posedge clock);
			chk(osc0, compExp(sel[2]), "aux osc 0 composite");
			chk(auxLoopComp, compExp(sel[0]), "aux loop dest");
			chk(ptdComp, compExp(sel[1]), "detector dest");
			chk(osc1, compExp(sel[3]), "aux osc 1 dest");
			chk(mz, compExp(sel[4]), "main zero dest");
			chk(mo, compExp(sel[5]), "main one dest");
		end
		// Live follow, then ramp limits for every nonzero slew code
		wreg(`SCC_IDX_ROUTE_OSC, 8'h01);
		for (int n = 1; n < 8; n++) begin
			wreg(`SCC_IDX_SLEW, 8'h00);
			fcf <= 32'h40000000 + ($random(seed) & 32'h000FFFFF);
			repeat (4) @(posedge clock);
			chk(osc0, fcf, "unlimited follow");
			c0 = fcf;
			wreg(`SCC_IDX_SLEW, n[7:0]);
			fcf <= fcf + 32'h00001000;
			repeat (32) @(posedge clock);
			d0 = osc0 - c0;
			chk(d0 <= (9 << (n - 1)) && d0 >= (6 << (n - 1)), 1'b1, "slew step size");
		end
		// Aux loop: nominal period 100 cycles, bandwidth zero first
		wreg(`SCC_IDX_SLEW, 8'h00);
		wreg(`SCC_IDX_NOM0, 8'h64);
		edges(12, 100);
		chk(auxHoldover, 1'b1, "holdover with zero bw");
		chk(cf3, 32'h40000000, "factor frozen with zero bw");
		wreg(`SCC_IDX_BW_HI, 8'h01);
		edges(12, 100);
		chk(auxHoldover, 1'b0, "closed after lock");
		apb(1'b0, `SCC_IDX_LIVE, 8'h00);
		chk(rd & 32'h2, 32'h2, "live lock");
		apb(1'b0, `SCC_IDX_EVENT, 8'h00);
		chk(rd & 32'h1, 32'h1, "locked event");
		// One cycle shorter period adds exactly one LSB per edge at bw 256
		edges(1, 100);
		c0 = cfLast;
		edges(1, 100);
		d0 = cfLast - c0;
		edges(2, 99);
		c0 = cfLast;
		edges(1, 99);
		chk(cfLast - c0, 32'h00000001, "factor update per edge");
		// Period off by more than one percent, long then short
		for (int k = 0; k < 2; k++) begin
			edges(2, k ? 97 : 110);
			c0 = cfLast;
			edges(3, k ? 97 : 110);
			chk(auxHoldover, 1'b1, "holdover on period error");
			chk(cfLast, c0, "frozen factor");
			apb(1'b0, `SCC_IDX_LIVE, 8'h00);
			chk(rd & 32'h4, 32'h4, "live fault");
			apb(1'b0, `SCC_IDX_EVENT, 8'h00);
			chk(rd & 32'h4, 32'h4, "faulted event");
			if (k == 0) chk(rd & 32'h2, 32'h2, "unlocked event");
			edges(14, 100);
			chk(auxHoldover, 1'b0, "resume after fault");
			apb(1'b0, `SCC_IDX_EVENT, 8'h00);
			chk(rd & 32'h8, 32'h8, "unfaulted event");
			apb(1'b0, `SCC_IDX_LIVE, 8'h00);
			chk(rd & 32'h6, 32'h2, "live after recovery");
		end
		// Bandwidth back to zero holds over even when locked and unfaulted
		wreg(`SCC_IDX_BW_HI, 8'h00);
		edges(12, 100);
		chk(auxHoldover, 1'b1, "holdover on zero bw");
		apb(1'b0, `SCC_IDX_LIVE, 8'h00);
		chk(rd & 32'h7, 32'h3, "live at zero bw");
		finish_test();
	end
endmodule

`default_nettype wire
